// [logic/pca_arbiter.sv]
module pca_arbiter
  import pca_pkg::*;
#(
  parameter logic [TMR_W-1:0] MTT_PRESET = MTT_DEF,
  parameter logic [TMR_W-1:0] MLT_PRESET = MLT_DEF
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [3:0]  pci_req_n_i,
  output logic      [3:0]  pci_gnt_n_o,
  input  wire logic        bridge_hold_request_n_i,
  output logic             bridge_hold_grant_n_o,
  input  wire logic        frame_n_i,
  input  wire logic        irdy_n_i,
  input  wire logic        lock_n_i,
  input  wire logic        pci_mem_access_i,
  output logic             cpu_grant_o,
  output logic      [31:0] ad_o,
  output logic             ad_oe_n_o,
  output logic      [3:0]  cbe_n_o,
  output logic             cbe_oe_n_o,
  output logic             par_o,
  output logic             par_oe_n_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pca_state_e  state_ff, nxt_state;
  logic [4:0]  gnt_ff, nxt_gnt;
  logic [2:0]  top_ff, nxt_top;
  logic [2:0]  last_ff, nxt_last;
  logic [1:0]  turn_ff, nxt_turn;
  logic        cpu_ff, nxt_cpu;
  logic        park_ff, nxt_park;

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  // bridge pair
  wire  [4:0] req_raw    = {~bridge_hold_request_n_i, ~pci_req_n_i};
  wire        others     = |req_raw[3:0];
  wire        mask_brg   = (last_ff == BRIDGE_IDX) && others;
  wire  [4:0] req_v      = {req_raw[4] & ~mask_brg, req_raw[3:0]};
  wire        bus_idle   = frame_n_i & irdy_n_i;
  wire        mtt_zero;
  wire        mlt_zero;
  wire        wait_zero;
  wire  [2:0] ring_top   = (!mtt_zero && last_ff != NO_AGENT) ? last_ff : top_ff;
  wire        cpu_hi     = (turn_ff == CPU_TURN);
  wire        cpu_take   = cpu_hi && !lock_n_i == 1'b0;
  wire        pci_start  = (state_ff == PCA_IDLE) && !cpu_take && |req_v;
  wire        cpu_start  = (state_ff == PCA_IDLE) && cpu_take;
  wire        gnt_any    = |gnt_ff;

  logic [2:0] winner;
  logic       found;
  always_comb begin
    logic [2:0] idx;
    idx    = '0;
    winner = NO_AGENT;
    found  = 1'b0;
    for (int i = 0; i < NUM_AGENTS; i++) begin
      idx = 3'((32'(ring_top) + i) % NUM_AGENTS);
      if (!found && req_v[idx]) begin
        winner = idx;
        found  = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  // load on every PCI agent grant
  pca_down_timer #(.W(TMR_W)) u_mtt (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .load_i     (pci_start),
    .load_val_i (MTT_PRESET),
    .zero_o     (mtt_zero)
  );

  pca_down_timer #(.W(TMR_W)) u_mlt (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .load_i     (cpu_start),
    .load_val_i (MLT_PRESET),
    .zero_o     (mlt_zero)
  );

  // Loaded one short: the grant itself occupies the first clock
  pca_down_timer #(.W(TMR_W)) u_wait (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .load_i     (pci_start),
    .load_val_i (TMR_W'(GNT_WAIT - 8'h01)),
    .zero_o     (wait_zero)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_gnt   = gnt_ff;
    nxt_top   = top_ff;
    nxt_last  = last_ff;
    nxt_turn  = turn_ff;
    case (state_ff)
      PCA_IDLE: begin
        if (cpu_take) begin
          nxt_state = PCA_CPU;
        end else if (found) begin
          nxt_gnt   = 5'(5'h01 << winner);
          nxt_state = PCA_GNT;
          nxt_last  = winner;
          nxt_top   = (winner == BRIDGE_IDX) ? 3'h0 : 3'(winner + 3'h1);
          if (winner != last_ff && !cpu_hi) begin
            nxt_turn = 2'(turn_ff + 2'h1);
          end
        end
      end
      PCA_GNT: begin
        if (!frame_n_i) begin
          nxt_gnt   = '0;
          nxt_state = PCA_BUSY;
        end else if (wait_zero) begin
          nxt_gnt   = '0;
          nxt_state = PCA_IDLE;
        end
      end
      PCA_BUSY: begin
        if (bus_idle) begin
          nxt_state = PCA_IDLE;
        end
      end
      PCA_CPU: begin
        if (mlt_zero) begin
          nxt_state = PCA_IDLE;
          nxt_turn  = '0;
        end
      end
      default: begin
        nxt_state = PCA_IDLE;
        nxt_gnt   = '0;
      end
    endcase
  end

  // CPU grant conditions; concurrent with peer traffic
  assign nxt_cpu  = (nxt_state == PCA_CPU) || (!pci_mem_access_i && lock_n_i);
  assign nxt_park = (nxt_state == PCA_IDLE) && (nxt_gnt == '0) && bus_idle;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // asynchronous reset; counts on PCI clock
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= PCA_IDLE;
      gnt_ff   <= '0;
      top_ff   <= TOP_RST;
      last_ff  <= NO_AGENT;
      turn_ff  <= '0;
      cpu_ff   <= 1'b0;
      park_ff  <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      gnt_ff   <= nxt_gnt;
      top_ff   <= nxt_top;
      last_ff  <= nxt_last;
      turn_ff  <= nxt_turn;
      cpu_ff   <= nxt_cpu;
      park_ff  <= nxt_park;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pci_gnt_n_o           = ~gnt_ff[3:0];
  assign bridge_hold_grant_n_o = ~gnt_ff[4];
  assign cpu_grant_o           = cpu_ff;
  // zeros driven while parked, including reset
  assign ad_o       = PARK_AD;
  assign cbe_n_o    = PARK_CBE;
  assign par_o      = PARK_PAR;
  assign ad_oe_n_o  = ~park_ff;
  assign cbe_oe_n_o = ~park_ff;
  assign par_oe_n_o = ~park_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_grant_onehot: assert property (
    $onehot0(gnt_ff)) else $error("more than one grant");

  a_frame_release: assert property (
    (gnt_any && !frame_n_i) |=> !gnt_any) else $error("grant held after frame");

  a_grant_timeout: assert property (
    $rose(gnt_any) ##0 frame_n_i [*8] ##1 frame_n_i [*8] |=> !gnt_any)
    else $error("grant exceeded 16 clocks");

  a_bottom_move: assert property (
    pci_start |=> top_ff == ((last_ff == BRIDGE_IDX) ? 3'h0 : 3'(last_ff + 3'h1)))
    else $error("granted agent not moved to bottom");

  a_bridge_mask: assert property (
    (pci_start && last_ff == BRIDGE_IDX && others) |=> !gnt_ff[4])
    else $error("bridge granted back to back");

  a_cpu_exclusive: assert property (
    (state_ff == PCA_CPU) |-> !gnt_any && cpu_grant_o) else $error("PCI grant during CPU share");

  a_cpu_turn: assert property (
    (state_ff == PCA_IDLE && turn_ff == CPU_TURN && lock_n_i) |=> state_ff == PCA_CPU)
    else $error("CPU not raised after three grants");

  a_mtt_owner: assert property (
    (pci_start && !mtt_zero && req_v[last_ff[2:0]] && last_ff != NO_AGENT)
    |=> gnt_ff[$past(last_ff)]) else $error("timer owner lost priority");

  a_park_idle: assert property (
    (state_ff == PCA_IDLE && !gnt_any && $past(bus_idle) && $past(state_ff) == PCA_IDLE
     && $past(gnt_ff) == '0) |-> !ad_oe_n_o) else $error("bus not parked");

endmodule : pca_arbiter

// [shared/pca_pkg.sv]
package pca_pkg;

  // ----------------------------------------------------------------
  // Agents on the ring: general masters 0..3, bridge last
  // ----------------------------------------------------------------
  localparam int unsigned   NUM_GEN     = 4;
  localparam int unsigned   NUM_AGENTS  = 5;
  localparam logic [2:0]    BRIDGE_IDX  = 3'h4;
  localparam logic [2:0]    NO_AGENT    = 3'h7;

  // ----------------------------------------------------------------
  // Timer width, and timing counts in PCI clocks; CPU_TURN counts grants
  // ----------------------------------------------------------------
  localparam int unsigned   TMR_W       = 8;
  localparam logic [7:0]    GNT_WAIT    = 8'h10;
  localparam logic [7:0]    MTT_DEF     = 8'h20;
  localparam logic [7:0]    MLT_DEF     = 8'h20;
  localparam logic [1:0]    CPU_TURN    = 2'h3;
  localparam int unsigned   CPU_PCI_DIV = 2;

  // ----------------------------------------------------------------
  // Parking values and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0]   PARK_AD     = 32'h0000_0000;
  localparam logic [3:0]    PARK_CBE    = 4'h0;
  localparam logic          PARK_PAR    = 1'b0;
  localparam logic [3:0]    GNT_N_RST   = 4'hf;
  localparam logic [2:0]    TOP_RST     = 3'h0;

  typedef enum logic [1:0] {
    PCA_IDLE = 2'b00,
    PCA_GNT  = 2'b01,
    PCA_BUSY = 2'b10,
    PCA_CPU  = 2'b11
  } pca_state_e;

endpackage : pca_pkg

// [logic/pca_down_timer.sv]
module pca_down_timer
  import pca_pkg::*;
#(
  parameter int unsigned W = TMR_W
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_val_i,
  output logic              zero_o
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  // Saturates at zero so an idle timer costs no toggling
  assign nxt_cnt = load_i ? load_val_i :
                   (cnt_ff != '0) ? W'(cnt_ff - 1'b1) : cnt_ff;
  assign zero_o  = (cnt_ff == '0);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule : pca_down_timer

// [tb/pca_master_model.sv]
module pca_master_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [4:0] want_i,
  input  wire logic [4:0] gnt_i,
  input  wire logic       stall_i,
  output logic      [4:0] req_n_o,
  output logic            frame_n_o,
  output logic            irdy_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // Masters and bridge on the far side of the grant lines
  // ---------------------------------------------------------------
  logic [2:0] cnt_ff;
  logic [4:0] own_ff;
  // request pairs, dropped once own cycle starts
  assign req_n_o   = ~(want_i & ~own_ff);
  // Last data phase: frame released one clock before irdy
  assign frame_n_o = ~(cnt_ff > 3'h1);
  assign irdy_n_o  = ~(cnt_ff != 3'h0);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= 3'h0;
      own_ff <= 5'h00;
    end else if (cnt_ff != 3'h0) begin
      cnt_ff <= cnt_ff - 3'h1;
      if (cnt_ff == 3'h1) begin
        own_ff <= 5'h00;
      end
    end else if ((gnt_i != 5'h00) && !stall_i) begin
      // Stalled masters never start, so the grant must time out
      cnt_ff <= 3'h4;
      own_ff <= gnt_i;
    end
  end
endmodule : pca_master_model

// [tb/pci_central_arbiter_tb.sv]
module pci_central_arbiter_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 0, rst_n_i = 0, frame_n, irdy_n, lock_n = 1, mem = 1;
  logic stall = 0, prio = 0, rot = 0, bgnt_n, cpu_g, par, ad_oe, cbe_oe, par_oe;
  logic [4:0]  want = 5'h00, g, prev_g = 5'h00, req_n;
  logic [3:0]  gnt_n, cbe;
  logic [31:0] ad;
  int errors = 0, num_checks = 0, len = 0, last = 4, pcnt = 0, idle = 0, cpu_seen = 0;
  // Stall as the master saw it when the grant arrived, not when it ends
  logic gst = 0;
  integer seed = 32'hbb843286;
  assign g = ~{bgnt_n, gnt_n};
  always #2.5 clk_i = ~clk_i;
  pca_arbiter #(.MTT_PRESET(8'h2), .MLT_PRESET(8'h4)) DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .pci_req_n_i(req_n[3:0]), .pci_gnt_n_o(gnt_n),
    .bridge_hold_request_n_i(req_n[4]), .bridge_hold_grant_n_o(bgnt_n),
    .frame_n_i(frame_n), .irdy_n_i(irdy_n), .lock_n_i(lock_n), .pci_mem_access_i(mem),
    .cpu_grant_o(cpu_g), .ad_o(ad), .ad_oe_n_o(ad_oe), .cbe_n_o(cbe),
    .cbe_oe_n_o(cbe_oe), .par_o(par), .par_oe_n_o(par_oe));
  pca_master_model PM (.clk_i(clk_i), .rst_n_i(rst_n_i), .want_i(want), .gnt_i(g),
    .stall_i(stall), .req_n_o(req_n), .frame_n_o(frame_n), .irdy_n_o(irdy_n));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task wrap_up;
    $display("Checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  task cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  task wait_g;
    for (int i = 0; i < 40 && g == 5'h00; i++) cyc(1);
    check(g != 5'h00, 1);
  endtask : wait_g
  function int nxt(input int a);
    return (a + 1) % 5;
  endfunction : nxt
  function int idx(input logic [4:0] v);
    for (int i = 0; i < 5; i++) if (v[i]) return i;
    return 0;
  endfunction : idx
  // ---------------------------------------------------------------
  // Monitor on every edge; outputs are registered, so pre-edge values
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      prev_g = 0; len = 0; idle = 0; last = 4; pcnt = 0;
    end else begin
      check($onehot0(g), 1);
      if (g != prev_g && prev_g != 0) check(len, gst ? 16 : 2);
      if (g != 0 && g != prev_g) begin
        if (rot) check(idx(g), nxt(last));
        if (prio) check(pcnt < 3, 1);
        pcnt++;
        last = idx(g);
        len = 1;
        gst = stall;
      end else if (g != 0) len++;
      if (cpu_g === 1'b1 && prio) begin
        check(g, 0);
        cpu_seen = 1;
        pcnt = 0;
      end
      // CPU share keeps the bus unparked, so those clocks are not idle
      idle = (g == 0 && frame_n && irdy_n && !cpu_g) ? idle + 1 : 0;
      if (idle > 1) check({ad_oe, cbe_oe, par_oe, ad, cbe, par}, 0);
      if (g != 0 && prev_g == g) check({ad_oe, cbe_oe, par_oe}, 3'h7);
      prev_g = g;
    end
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    cyc(4);
    check({ad_oe, cbe_oe, par_oe, ad, cbe, par, gnt_n, bgnt_n}, 5'h1f);
    rst_n_i = 1;
    want = 5'h1f; prio = 1; rot = 1;
    cyc(200);
    check(cpu_seen, 1);
    // Timeouts cost 16 clocks each, so only a few rounds fit
    stall = 1;
    cyc(120);
    want = 0;
    cyc(30);
    stall = 0; prio = 0; rot = 0; mem = 0;
    cyc(4);
    check(cpu_g, 1);
    lock_n = 0;
    cyc(12);
    check(cpu_g, 0);
    lock_n = 1; want = 5'h04;
    wait_g();
    check(cpu_g, 1);
    for (int i = 0; i < 200; i++) begin
      want = 5'($random(seed));
      mem = 1'($random(seed));
      lock_n = ($random(seed) & 7) != 0;
      cyc(1 + ($random(seed) & 7));
    end
    want = 5'h1f;
    wait_g();
    rst_n_i = 0;
    #1 check({gnt_n, bgnt_n, cpu_g, ad_oe, cbe_oe, par_oe}, 9'h1f0);
    want = 0;
    cyc(3);
    rst_n_i = 1;
    cyc(5);
    wrap_up();
  end
  initial begin
    #50000;
    errors++;
    wrap_up();
  end
endmodule : pci_central_arbiter_tb
